/* core/pca_defines.svh */
//==============================================================
// Purpose: offsets, field positions, reset values, timing counts
// Assumes: 125 MHz ref_clk, one sample per adc_valid pulse
// Notes:   included by the core and the package users
`ifndef PCA_DEFINES_SVH
`define PCA_DEFINES_SVH
//==============================================================
// register byte offsets
`define PCA_CTRL    8'h00
`define PCA_STAT    8'h04
`define PCA_LTC     8'h08
`define PCA_STC     8'h0C
`define PCA_MRISE   8'h10
`define PCA_MFLAT   8'h14
`define PCA_FRISE   8'h18
`define PCA_FFLAT   8'h1C
`define PCA_THRM    8'h20
`define PCA_THRF    8'h24
`define PCA_BLSH    8'h28
`define PCA_GSH     8'h2C
`define PCA_AUXDLY  8'h30
`define PCA_CWID    8'h34
`define PCA_PKDLY   8'h38
`define PCA_PRESET  8'h3C
`define PCA_REAL_LO 8'h40
`define PCA_REAL_HI 8'h44
`define PCA_LIVE_LO 8'h48
`define PCA_LIVE_HI 8'h4C
`define PCA_ICR     8'h50
`define PCA_HADDR   8'h54
`define PCA_HDATA   8'h58
//==============================================================
// control field positions
`define PCA_B_START  0
`define PCA_B_PLIVE  1
`define PCA_B_AUTO   2
`define PCA_B_ANTI   3
`define PCA_B_MODE   4
`define PCA_B_POLLOW 6
`define PCA_B_ICRM   7
`define PCA_B_INHLOW 8
`define PCA_B_CLR    9
//==============================================================
// timing: times as printed, counts derived
`define PCA_CLK_NS        8
`define PCA_SAMPLE_PS     12500
`define PCA_TC_STEP_PS    1600
`define PCA_TICK_NS       200
`define PCA_TICK_CYC      (`PCA_TICK_NS / `PCA_CLK_NS)
`define PCA_PRESET_NS     10000000
`define PCA_PRESET_TICKS  (`PCA_PRESET_NS / `PCA_TICK_NS)
`define PCA_DLY_MAX_NS    51000
`define PCA_DLY_MAX       (`PCA_DLY_MAX_NS * 1000 / `PCA_SAMPLE_PS)
`define PCA_MRISE_MIN     (100 * 1000 / `PCA_SAMPLE_PS)
`define PCA_MRISE_MAX     (25000 * 1000 / `PCA_SAMPLE_PS)
`define PCA_FLAT_MAX      (3200 * 1000 / `PCA_SAMPLE_PS)
`define PCA_FRISE_MAX     (12750 * 1000 / `PCA_SAMPLE_PS)
`define PCA_LTC_MIN       (400 * 1000 / `PCA_TC_STEP_PS)
`define PCA_LTC_MAX       (6400 * 1000 / `PCA_TC_STEP_PS)
`define PCA_STC_MAX       (200 * 1000 / `PCA_TC_STEP_PS)
// reset values and channel maximum
`define PCA_LTC_RST       13'h0FA0
`define PCA_STC_RST       13'h0001
`define PCA_MRISE_RST     13'h0050
`define PCA_FLAT_RST      13'h0008
`define PCA_FRISE_RST     13'h0008
`define PCA_THR_RST       14'h0040
`define PCA_DLY_RST       13'h0001
`define PCA_CHAN_MAX      14'h3FFF
`endif

/* core/pca_pkg.sv */
//==============================================================
// Purpose: types shared by the acquisition core
// Assumes: nothing
// Notes:   constants live in pca_defines.svh
package pca_pkg;
  // auxiliary input use
  typedef enum logic [1:0] {AUX_ANALOG, AUX_LEVEL, AUX_EDGE} pca_aux_type;
  typedef enum logic {ACQ_IDLE, ACQ_RUN} pca_acq_type;
  // one sample of the delayed peak stream
  typedef struct packed {
    logic        strobe;
    logic [13:0] chan;
  } pca_evt_type;
endpackage : pca_pkg

/* core/pca_core.sv */
//==============================================================
// Purpose: pulse processing, coincidence gating and 16k histogram
// Assumes: adc_data/adc_valid/aux_adc_data come from ref_clk logic
// Notes:   pins aux_pin_in and inhibit_pin_in are synchronised
// Summary of operation
// - aux input defaults to analog slow converter, optionally coincidence logic input
// - coincidence gating off when aux is analog, on otherwise
// - aux active sense is high, low or edge; source must drive it
// - timing strobe compared with delayed aux level or edge pulse
// - window or edge-pulse mode, each coincidence or anti-coincidence
// - generated pulse starts on selected rising or falling aux edge
// - aux delay programmable from one sample to 51 us
// - generated window width programmable from one sample to 51 us
// - one-sample peak strobe with programmable delay up to 51 us
// - take 16-bit converter samples every 12.5 ns
// - primary decay cancel 400 ns to 6.4 us, 1.6 ns steps
// - secondary decay cancel 1.6 ns to 200 ns, 1.6 ns steps
// - main trapezoid rise 100 ns to 25 us in sample steps
// - main flat top one sample to 3.2 us
// - fast trapezoid rise one sample to 12.75 us
// - fast flat top one sample to 3.2 us
// - thresholds automatic in four-channel steps or manual with one channel granularity
// - base line restored by gated high-pass with adjustable response
// - histogram of 16384 channels, 32-bit unsigned counts
// - real and live timers at 200 ns; preset stop in 10 ms units
// - pile-up rejected by pulse interval and fast pulse width
// - extended paralyzable dead time; rate estimate corrects pile-up losses
// - inhibit suspends histogram, live timer and base line tracking
`timescale 1ns/1ns
`default_nettype none
`include "pca_defines.svh"

module pca_core
  import pca_pkg::*;
#(
  parameter int unsigned PRESET_TICKS = `PCA_PRESET_TICKS
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        adc_valid,
  input  wire logic [15:0] adc_data,
  input  wire logic [11:0] aux_adc_data,
  input  wire logic        aux_pin_in,
  input  wire logic        inhibit_pin_in,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             aux_analog_sel
);
  //============================================================
  // pin synchronisers
  logic [1:0] aux_s_q;
  logic [1:0] inh_s_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aux_s_q <= 2'h0;
      inh_s_q <= 2'h0;
    end else begin
      aux_s_q <= {aux_s_q[0], aux_pin_in};
      inh_s_q <= {inh_s_q[0], inhibit_pin_in};
    end
  end

  //============================================================
  // bus slave: one wait cycle per access
  logic        wait_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  wire acc_wr = avs_write & ~wait_q;
  wire acc_rd = avs_read & ~wait_q;
  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rd_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 1'b1;
      rd_q   <= 32'h0;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      if (avs_read & wait_q) rd_q <= rd_d;
    end
  end

  function automatic logic [12:0] clampc(input logic [31:0] v, input int lo, input int hi);
    if (v < 32'(lo)) return 13'(lo);
    if (v > 32'(hi)) return 13'(hi);
    return v[12:0];
  endfunction : clampc

  function automatic logic [13:0] sat14(input logic signed [47:0] v);
    if (v < 48'sh0) return 14'h0;
    if (v > $signed({34'h0, `PCA_CHAN_MAX})) return `PCA_CHAN_MAX;
    return v[13:0];
  endfunction : sat14

  //============================================================
  // configuration
  logic        plive_q, auto_q, anti_q, pol_low_q, icr_main_q, inh_low_q, analog_q;
  pca_aux_type mode_q;
  logic [12:0] ltc_q, stc_q, mrise_q, mflat_q, frise_q, fflat_q;
  logic [12:0] auxdly_q, cwid_q, pkdly_q;
  logic [13:0] thrm_q, thrf_q;
  logic [3:0]  blsh_q;
  logic [5:0]  gsh_q;
  logic [31:0] preset_q;
  wire  [31:0] wd = avs_writedata;
  assign aux_analog_sel = analog_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {plive_q, auto_q, anti_q, pol_low_q, icr_main_q, inh_low_q} <= 6'h0;
      mode_q   <= AUX_ANALOG;
      analog_q <= 1'b1;
      ltc_q    <= `PCA_LTC_RST;
      stc_q    <= `PCA_STC_RST;
      mrise_q  <= `PCA_MRISE_RST;
      mflat_q  <= `PCA_FLAT_RST;
      frise_q  <= `PCA_FRISE_RST;
      fflat_q  <= `PCA_FLAT_RST;
      auxdly_q <= `PCA_DLY_RST;
      cwid_q   <= `PCA_DLY_RST;
      pkdly_q  <= `PCA_DLY_RST;
      thrm_q   <= `PCA_THR_RST;
      thrf_q   <= `PCA_THR_RST;
      blsh_q   <= 4'h8;
      gsh_q    <= 6'h10;
      preset_q <= 32'h0;
    end else if (acc_wr) begin
      case (avs_address)
        `PCA_CTRL: begin
          plive_q    <= wd[`PCA_B_PLIVE];
          auto_q     <= wd[`PCA_B_AUTO];
          anti_q     <= wd[`PCA_B_ANTI];
          pol_low_q  <= wd[`PCA_B_POLLOW];
          icr_main_q <= wd[`PCA_B_ICRM];
          inh_low_q  <= wd[`PCA_B_INHLOW];
          // code 3 is not a mode; fall back to analog
          mode_q   <= (&wd[`PCA_B_MODE+:2]) ? AUX_ANALOG : pca_aux_type'(wd[`PCA_B_MODE+:2]);
          analog_q <= (wd[`PCA_B_MODE+:2] == 2'h0) | (&wd[`PCA_B_MODE+:2]);
        end
        `PCA_LTC:    ltc_q    <= clampc(wd, `PCA_LTC_MIN, `PCA_LTC_MAX);
        `PCA_STC:    stc_q    <= clampc(wd, 1, `PCA_STC_MAX);
        `PCA_MRISE:  mrise_q  <= clampc(wd, `PCA_MRISE_MIN, `PCA_MRISE_MAX);
        `PCA_MFLAT:  mflat_q  <= clampc(wd, 1, `PCA_FLAT_MAX);
        `PCA_FRISE:  frise_q  <= clampc(wd, 1, `PCA_FRISE_MAX);
        `PCA_FFLAT:  fflat_q  <= clampc(wd, 1, `PCA_FLAT_MAX);
        `PCA_AUXDLY: auxdly_q <= clampc(wd, 1, `PCA_DLY_MAX);
        `PCA_CWID:   cwid_q   <= clampc(wd, 1, `PCA_DLY_MAX);
        `PCA_PKDLY:  pkdly_q  <= clampc(wd, 1, `PCA_DLY_MAX);
        `PCA_THRM:   thrm_q   <= wd[13:0];
        `PCA_THRF:   thrf_q   <= wd[13:0];
        `PCA_BLSH:   blsh_q   <= wd[3:0];
        `PCA_GSH:    gsh_q    <= wd[5:0];
        `PCA_PRESET: preset_q <= wd;
        default: ;
      endcase
    end
  end

  wire inhib = inh_s_q[1] ^ inh_low_q;
  wire ctrl_wr = acc_wr & (avs_address == `PCA_CTRL);
  wire clr_wr  = ctrl_wr & wd[`PCA_B_CLR];
  wire smp     = adc_valid;

  //============================================================
  // base line, decay cancellation, shaping
  logic signed [24:0] bl_q;
  logic signed [47:0] xp_q, y1p_q, v_q, tm_q, tf_q;
  logic        [12:0] wp_q;
  logic signed [47:0] vring [8192];
  logic               fdisc_q;
  logic        [12:0] dead_q;
  wire signed [16:0] xs = $signed({1'b0, adc_data}) - bl_q[24:8];
  wire signed [47:0] x48 = 48'(xs);
  wire signed [47:0] y1 = x48 * 48'sd125 + (x48 - xp_q) * $signed({35'h0, ltc_q}) * 48'sd16;
  wire signed [47:0] y2 = y1 * 48'sd125 + (y1 - y1p_q) * $signed({35'h0, stc_q}) * 48'sd16;
  wire signed [47:0] vn = v_q + y2;
  wire signed [47:0] tm_n = tm_q + vn - vring[wp_q - mrise_q] - vring[wp_q - mrise_q - mflat_q]
                          + vring[wp_q - (mrise_q << 1) - mflat_q];
  wire signed [47:0] tf_n = tf_q + vn - vring[wp_q - frise_q] - vring[wp_q - frise_q - fflat_q]
                          + vring[wp_q - (frise_q << 1) - fflat_q];
  wire        [13:0] mh = sat14(tm_n >>> gsh_q);
  wire        [13:0] fh = sat14(tf_n >>> gsh_q);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bl_q  <= 25'sh0;
      xp_q  <= 48'sh0;
      y1p_q <= 48'sh0;
      v_q   <= 48'sh0;
      tm_q  <= 48'sh0;
      tf_q  <= 48'sh0;
      wp_q  <= 13'h0;
    end else if (smp) begin
      // tracking frozen around pulses so they do not pull the base line
      if (~fdisc_q & (dead_q == 13'h0) & ~inhib)
        bl_q <= bl_q + ($signed({xs, 8'h00}) >>> blsh_q);
      xp_q  <= x48;
      y1p_q <= y1;
      v_q   <= vn;
      tm_q  <= tm_n;
      tf_q  <= tf_n;
      wp_q  <= wp_q + 13'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (smp) vring[wp_q] <= vn;
  end

  //============================================================
  // thresholds, peak strobe, pile-up, dead time
  logic [21:0] nz_q;
  logic [12:0] pk_q, fw_q;
  logic        pu_q;
  wire  [13:0] thr_a = {nz_q[19:8], 2'h0};
  wire  [13:0] thr_f = auto_q ? thr_a : thrf_q;
  wire  [13:0] thr_m = auto_q ? thr_a : thrm_q;
  wire         fdisc = fh > thr_f;
  wire         frise = smp & fdisc & ~fdisc_q;
  wire         wid_pu = smp & fdisc & (fw_q == frise_q + fflat_q + 13'h1);
  wire         pk_str = smp & (pk_q == 13'h1);
  pca_evt_type evt_d;
  assign evt_d.strobe = pk_str & ~pu_q & (mh > thr_m);
  assign evt_d.chan   = mh;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      nz_q    <= 22'h0;
      fdisc_q <= 1'b0;
      pk_q    <= 13'h0;
      fw_q    <= 13'h0;
      pu_q    <= 1'b0;
      dead_q  <= 13'h0;
    end else if (smp) begin
      fdisc_q <= fdisc;
      if (~fdisc)
        nz_q <= 22'($signed({1'b0, nz_q}) + ($signed({1'b0, fh, 8'h00}) - $signed({1'b0, nz_q}))
                    >>> 4);
      fw_q <= fdisc ? fw_q + 13'h1 : 13'h0;
      if (frise) begin
        pu_q <= (pk_q != 13'h0);
        pk_q <= mrise_q + (mflat_q >> 1);
      end else begin
        if (wid_pu) pu_q <= 1'b1;
        if (pk_q != 13'h0) pk_q <= pk_q - 13'h1;
      end
      // every new pulse restarts the dead period: paralyzable
      if (frise) dead_q <= (mrise_q << 1) + mflat_q;
      else if (dead_q != 13'h0) dead_q <= dead_q - 13'h1;
    end
  end

  //============================================================
  // coincidence delay lines and window
  logic        aux_ring [4096];
  pca_evt_type evt_ring [4096];
  logic [11:0] cp_q;
  logic [12:0] win_q;
  logic        auxp_q;
  wire         aux_dl = aux_ring[cp_q - auxdly_q[11:0]];
  pca_evt_type evt_dl;
  assign evt_dl = evt_ring[cp_q - pkdly_q[11:0]];
  wire edge_hit = pol_low_q ? (auxp_q & ~aux_dl) : (aux_dl & ~auxp_q);
  logic in_win;
  always_comb begin
    unique case (mode_q)
      AUX_LEVEL: in_win = aux_dl ^ pol_low_q;
      AUX_EDGE:  in_win = edge_hit | (win_q != 13'h0);
      default:   in_win = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cp_q   <= 12'h0;
      win_q  <= 13'h0;
      auxp_q <= 1'b0;
    end else if (smp) begin
      cp_q   <= cp_q + 12'h1;
      auxp_q <= aux_dl;
      if (edge_hit & (mode_q == AUX_EDGE)) win_q <= cwid_q - 13'h1;
      else if (win_q != 13'h0) win_q <= win_q - 13'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (smp) begin
      aux_ring[cp_q] <= aux_s_q[1];
      evt_ring[cp_q] <= evt_d;
    end
  end

  //============================================================
  // acquisition state, timers, rate estimate
  pca_acq_type acq_q;
  logic [4:0]  tk_q;
  logic [47:0] real_q, live_q;
  logic [31:0] sub_q, units_q, icr_q;
  wire tick    = (tk_q == 5'(`PCA_TICK_CYC - 1));
  wire run     = (acq_q == ACQ_RUN);
  wire live_en = tick & run & (dead_q == 13'h0) & ~inhib;
  wire pre_en  = plive_q ? live_en : (tick & run);
  wire pre_hit = (preset_q != 32'h0) & (units_q >= preset_q);
  wire accept  = smp & run & ~inhib & evt_dl.strobe
               & (analog_q | (anti_q ^ in_win));
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acq_q <= ACQ_IDLE;
    end else begin
      unique case (acq_q)
        ACQ_IDLE: if (ctrl_wr & wd[`PCA_B_START] & ~pre_hit) acq_q <= ACQ_RUN;
        ACQ_RUN:  if (pre_hit | (ctrl_wr & ~wd[`PCA_B_START])) acq_q <= ACQ_IDLE;
      endcase
    end
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tk_q    <= 5'h0;
      real_q  <= 48'h0;
      live_q  <= 48'h0;
      sub_q   <= 32'h0;
      units_q <= 32'h0;
      icr_q   <= 32'h0;
    end else if (clr_wr) begin
      {real_q, live_q} <= 96'h0;
      {sub_q, units_q, icr_q} <= 96'h0;
    end else begin
      tk_q <= tick ? 5'h0 : tk_q + 5'h1;
      if (tick & run) real_q <= real_q + 48'h1;
      if (live_en) live_q <= live_q + 48'h1;
      if (pre_en) begin
        if (sub_q == PRESET_TICKS - 1) begin
          sub_q   <= 32'h0;
          units_q <= units_q + 32'h1;
        end else begin
          sub_q <= sub_q + 32'h1;
        end
      end
      // piled-up pulses hide at least one more arrival
      if (run) begin
        if (icr_main_q) icr_q <= icr_q + {31'h0, pk_str} + {31'h0, pk_str & pu_q};
        else icr_q <= icr_q + {31'h0, frise} + {31'h0, wid_pu};
      end
    end
  end

  //============================================================
  // histogram: single-cycle increment, saturating
  logic [31:0] hist [16384];
  logic [13:0] haddr_q, inc_a_q;
  logic        inc_v_q;
  wire hd_acc = (acc_wr | acc_rd) & (avs_address == `PCA_HDATA);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      haddr_q <= 14'h0;
      inc_a_q <= 14'h0;
      inc_v_q <= 1'b0;
    end else begin
      inc_v_q <= accept;
      inc_a_q <= evt_dl.chan;
      if (acc_wr & (avs_address == `PCA_HADDR)) haddr_q <= wd[13:0];
      else if (hd_acc) haddr_q <= haddr_q + 14'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (inc_v_q) begin
      if (~&hist[inc_a_q]) hist[inc_a_q] <= hist[inc_a_q] + 32'h1;
    end else if (acc_wr & (avs_address == `PCA_HDATA) & ~run) begin
      hist[haddr_q] <= wd;
    end
  end

  //============================================================
  // read mux
  always_comb begin
    rd_d = 32'h0;
    case (avs_address)
      `PCA_CTRL:    rd_d = {23'h0, inh_low_q, icr_main_q, pol_low_q, mode_q, anti_q,
                            auto_q, plive_q, run};
      `PCA_STAT:    rd_d = {4'h0, analog_q ? aux_adc_data : 12'h0, 13'h0, inhib,
                            aux_s_q[1], run};
      `PCA_LTC:     rd_d = {19'h0, ltc_q};
      `PCA_STC:     rd_d = {19'h0, stc_q};
      `PCA_MRISE:   rd_d = {19'h0, mrise_q};
      `PCA_MFLAT:   rd_d = {19'h0, mflat_q};
      `PCA_FRISE:   rd_d = {19'h0, frise_q};
      `PCA_FFLAT:   rd_d = {19'h0, fflat_q};
      `PCA_THRM:    rd_d = {18'h0, thr_m};
      `PCA_THRF:    rd_d = {18'h0, thr_f};
      `PCA_BLSH:    rd_d = {28'h0, blsh_q};
      `PCA_GSH:     rd_d = {26'h0, gsh_q};
      `PCA_AUXDLY:  rd_d = {19'h0, auxdly_q};
      `PCA_CWID:    rd_d = {19'h0, cwid_q};
      `PCA_PKDLY:   rd_d = {19'h0, pkdly_q};
      `PCA_PRESET:  rd_d = preset_q;
      `PCA_REAL_LO: rd_d = real_q[31:0];
      `PCA_REAL_HI: rd_d = {16'h0, real_q[47:32]};
      `PCA_LIVE_LO: rd_d = live_q[31:0];
      `PCA_LIVE_HI: rd_d = {16'h0, live_q[47:32]};
      `PCA_ICR:     rd_d = icr_q;
      `PCA_HADDR:   rd_d = {18'h0, haddr_q};
      `PCA_HDATA:   rd_d = hist[haddr_q];
      default:      rd_d = 32'h0;
    endcase
  end
endmodule : pca_core
`default_nettype wire

/* verification/pca_core_properties.sv */
// Purpose: port-level properties of pca_core
// Assumes: single ref_clk domain, reset active high
// Notes:   bound to pca_core after the module
`timescale 1ns/1ns
`default_nettype none
`include "pca_defines.svh"
//==============================================================
// checker
module pca_core_properties
  import pca_pkg::*;
#(
  parameter int unsigned PRESET_TICKS = 4
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [11:0] aux_adc_data,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        aux_analog_sel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic req;
  logic ctrl_acc;
  assign req = avs_read || avs_write;
  assign ctrl_acc = avs_write && !avs_waitrequest && avs_address == `PCA_CTRL;
  AST_ANSWER_NEXT: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_NO_SPURIOUS: assert property ($fell(avs_waitrequest) |-> $past(req))
    else $error("answer without a request");
  AST_ANALOG_MODE: assert property (ctrl_acc && avs_writedata[5:4] inside {2'h0, 2'h3}
    |-> ##[1:2] aux_analog_sel) else $error("aux not analog");
  AST_DIGITAL_MODE: assert property (ctrl_acc && avs_writedata[5:4] inside {2'h1, 2'h2}
    |-> ##[1:2] !aux_analog_sel) else $error("aux still analog");
  AST_SEL_CAUSE: assert property ($changed(aux_analog_sel)
    |-> $past(ctrl_acc) || $past(ctrl_acc, 2)) else $error("aux select moved alone");
  AST_STAT_AUX: assert property (avs_read && avs_waitrequest && aux_analog_sel
    && avs_address == `PCA_STAT |=> avs_readdata[27:16] == $past(aux_adc_data))
    else $error("slow converter value missing");
  AST_UNMAPPED: assert property (avs_read && avs_waitrequest && avs_address > `PCA_HDATA
    |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
  cover property (ctrl_acc && avs_writedata[0]);
  cover property ($fell(aux_analog_sel));
  cover property (avs_read && !avs_waitrequest && avs_address == `PCA_STAT);
endmodule : pca_core_properties

bind pca_core pca_core_properties #(.PRESET_TICKS(PRESET_TICKS)) u_props (
  .ref_clk(ref_clk), .reset(reset), .aux_adc_data(aux_adc_data),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .aux_analog_sel(aux_analog_sel));
`default_nettype wire

/* verification/pca_fe_model.sv */
// Purpose: detector converter and coincidence source model
// Assumes: quiet base line, no pulses
// Notes:   aux pin always driven, the pin has no idle default
`timescale 1ns/1ns
`default_nettype none
//==============================================================
// front end
module pca_fe_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        aux_level,
  output logic             adc_valid,
  output logic      [15:0] adc_data,
  output logic             aux_pin
);
  logic [5:0] phase_q;
  // 12.5 ns samples on an 8 ns clock: 16 of every 25 cycles carry one
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_q <= 6'h00;
      adc_valid <= 1'b0;
      adc_data <= 16'h03E8;
    end else begin
      adc_valid <= (phase_q + 6'h10) >= 6'h19;
      phase_q <= ((phase_q + 6'h10) >= 6'h19) ? phase_q - 6'h09 : phase_q + 6'h10;
      adc_data <= 16'h03E8 + 16'($urandom_range(3, 0));
    end
  end
  always_ff @(posedge ref_clk) begin
    aux_pin <= aux_level;
  end
endmodule : pca_fe_model
`default_nettype wire

/* verification/tb.sv */
// Purpose: self-checking bench for pca_core
// Assumes: short preset unit through PRESET_TICKS
// Notes:   random seed fixed at 23
`timescale 1ns/1ns
`default_nettype none
`include "pca_defines.svh"
//==============================================================
// bench
module tb;
  import pca_pkg::*;
  localparam int unsigned PT = 4;
  logic ref_clk, reset, adc_valid, aux_pin_in, inhibit_pin_in, aux_lvl;
  logic avs_read, avs_write, avs_waitrequest, aux_analog_sel;
  logic [15:0] adc_data;
  logic [11:0] aux_adc_data;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, r0, r1, l0, l1;
  int failures, n_compared, cycles, v;
  int adr[9] = '{`PCA_LTC, `PCA_STC, `PCA_MRISE, `PCA_MFLAT, `PCA_FRISE, `PCA_FFLAT,
                 `PCA_AUXDLY, `PCA_CWID, `PCA_PKDLY};
  int lo[9] = '{`PCA_LTC_MIN, 1, `PCA_MRISE_MIN, 1, 1, 1, 1, 1, 1};
  int hi[9] = '{`PCA_LTC_MAX, `PCA_STC_MAX, `PCA_MRISE_MAX, `PCA_FLAT_MAX, `PCA_FRISE_MAX,
                `PCA_FLAT_MAX, `PCA_DLY_MAX, `PCA_DLY_MAX, `PCA_DLY_MAX};
  int rv[9] = '{`PCA_LTC_RST, `PCA_STC_RST, `PCA_MRISE_RST, `PCA_FLAT_RST, `PCA_FRISE_RST,
                `PCA_FLAT_RST, `PCA_DLY_RST, `PCA_DLY_RST, `PCA_DLY_RST};
  pca_core #(.PRESET_TICKS(PT)) uut (.ref_clk(ref_clk), .reset(reset), .adc_valid(adc_valid),
    .adc_data(adc_data), .aux_adc_data(aux_adc_data), .aux_pin_in(aux_pin_in),
    .inhibit_pin_in(inhibit_pin_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .aux_analog_sel(aux_analog_sel));
  pca_fe_model u_fe (.ref_clk(ref_clk), .reset(reset), .aux_level(aux_lvl),
    .adc_valid(adc_valid), .adc_data(adc_data), .aux_pin(aux_pin_in));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic int clamp(input int x, input int l, input int h);
    return (x < l) ? l : ((x > h) ? h : x);
  endfunction : clamp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // holds the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) failures++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    {reset, avs_read, avs_write, inhibit_pin_in, aux_lvl} = 5'b10000;
    {avs_address, avs_writedata, aux_adc_data} = '0;
    {failures, n_compared, cycles} = '0;
    v = $urandom(23);
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      bus(0, 8'(adr[i]), 0);
      chk(q, rv[i]);
      bus(1, 8'(adr[i]), 0);
      bus(0, 8'(adr[i]), 0);
      chk(q, lo[i]);
      bus(1, 8'(adr[i]), 32'h1FFF);
      bus(0, 8'(adr[i]), 0);
      chk(q, hi[i]);
      v = $urandom_range(hi[i] + 8, 0);
      bus(1, 8'(adr[i]), v);
      bus(0, 8'(adr[i]), 0);
      chk(q, clamp(v, lo[i], hi[i]));
    end
    for (int i = 0; i < 2; i++) begin
      bus(0, i ? `PCA_THRF : `PCA_THRM, 0);
      chk(q, `PCA_THR_RST);
      v = $urandom_range(16383, 0);
      bus(1, i ? `PCA_THRF : `PCA_THRM, v);
      bus(0, i ? `PCA_THRF : `PCA_THRM, 0);
      chk(q, v);
    end
    $display("test settings done");
    for (int m = 0; m < 4; m++) begin
      aux_adc_data <= 12'($urandom);
      aux_lvl <= 1'($urandom);
      bus(1, `PCA_CTRL, m << 4);
      repeat (4) @(posedge ref_clk);
      chk(aux_analog_sel, (m == 0 || m == 3));
      bus(0, `PCA_STAT, 0);
      chk(q[1], aux_lvl);
      if (m == 0 || m == 3) chk(q[27:16], aux_adc_data);
    end
    bus(1, 8'h5C, $urandom);
    bus(0, 8'h5C, 0);
    chk(q, 0);
    $display("test aux modes done");
    bus(1, `PCA_HADDR, 5);
    bus(1, `PCA_HDATA, 32'hFEDC_BA98);
    bus(1, `PCA_HADDR, 5);
    bus(0, `PCA_HDATA, 0);
    chk(q, 32'hFEDC_BA98);
    bus(0, `PCA_HADDR, 0);
    chk(q, 6);
    $display("test histogram access done");
    bus(1, `PCA_CTRL, 32'h200);
    bus(1, `PCA_CTRL, 1);
    for (int k = 0; k < 2; k++) begin
      inhibit_pin_in <= 1'(k);
      repeat (10) @(posedge ref_clk);
      bus(0, `PCA_REAL_LO, 0);
      r0 = q;
      bus(0, `PCA_LIVE_LO, 0);
      l0 = q;
      repeat (250) @(posedge ref_clk);
      bus(0, `PCA_REAL_LO, 0);
      r1 = q;
      bus(0, `PCA_LIVE_LO, 0);
      l1 = q;
      chk((r1 - r0) inside {32'd10, 32'd11}, 1);
      chk(k ? (l1 == l0) : ((l1 - l0) inside {32'd10, 32'd11}), 1);
    end
    inhibit_pin_in <= 1'b0;
    $display("test timers done");
    bus(1, `PCA_CTRL, 0);
    bus(1, `PCA_CTRL, 32'h200);
    bus(1, `PCA_PRESET, 2);
    bus(1, `PCA_CTRL, 1);
    for (int n = 0; n < 150; n++) begin
      bus(0, `PCA_STAT, 0);
      if (q[0] === 1'b0) break;
    end
    chk(q[0], 0);
    bus(0, `PCA_REAL_LO, 0);
    chk(q, 2 * PT);
    $display("test preset done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
